// ==== shared/dcc_pkg.sv ====
// Package: register map, field layout and types for DAC/comparator control
package dcc_pkg;
  // Register byte offsets (chosen map, one aligned word each)
  localparam logic [7:0] DCC_OFS_REF_CTRL = 8'h00;
  localparam logic [7:0] DCC_OFS_REF_LVL = 8'h04;
  localparam logic [7:0] DCC_OFS_C1_A = 8'h08;
  localparam logic [7:0] DCC_OFS_C1_B = 8'h0c;
  localparam logic [7:0] DCC_OFS_C2_A = 8'h10;
  localparam logic [7:0] DCC_OFS_C2_B = 8'h14;
  localparam logic [7:0] DCC_OFS_SUMMARY = 8'h18;
  localparam logic [7:0] DCC_OFS_IRQ_FLAGS = 8'h1c;
  // Reference converter control fields
  localparam int DCC_REF_ON_BIT = 7;
  localparam int DCC_REF_PIN_BIT = 5;
  localparam int DCC_REF_PSS_HI = 3;
  localparam int DCC_REF_PSS_LO = 2;
  localparam logic [7:0] DCC_REF_CTRL_MASK = 8'hac;
  localparam logic [7:0] DCC_REF_CTRL_RST = 8'h00;
  localparam logic [7:0] DCC_REF_LVL_RST = 8'h00;
  // Comparator control A fields
  localparam int DCC_CA_ON = 7;
  localparam int DCC_CA_RES = 6;
  localparam int DCC_CA_PIN = 5;
  localparam int DCC_CA_INV = 4;
  localparam int DCC_CA_SP = 2;
  localparam int DCC_CA_HYS = 1;
  localparam int DCC_CA_SYNC = 0;
  localparam logic [7:0] DCC_CA_WMASK = 8'hb7;
  localparam logic [7:0] DCC_CA_RST = 8'h04;
  // Comparator control B fields
  localparam int DCC_CB_RISE = 7;
  localparam int DCC_CB_FALL = 6;
  localparam int DCC_CB_PCH_HI = 5;
  localparam int DCC_CB_PCH_LO = 4;
  localparam logic [7:0] DCC_CB_WMASK = 8'hf7;
  localparam logic [7:0] DCC_CB_RST = 8'h00;
  localparam int DCC_NUM_CMP = 2;
  // Positive source encodings
  localparam logic [1:0] DCC_PSS_SUPPLY = 2'h0;
  localparam logic [1:0] DCC_PSS_EXTREF = 2'h1;
  localparam logic [1:0] DCC_PSS_FVR2 = 2'h2;
  // Comparator positive input encodings
  localparam logic [1:0] DCC_PCH_PIN = 2'h0;
  localparam logic [1:0] DCC_PCH_DAC = 2'h1;
  localparam logic [1:0] DCC_PCH_FVR2 = 2'h2;
  localparam logic [1:0] DCC_PCH_AGND = 2'h3;

  typedef struct packed {
    logic on;
    logic pin_drive;
    logic [1:0] pos_source_sel;
    logic [7:0] level_code;
  } dcc_ref_cfg_t;

  typedef struct packed {
    logic on;
    logic speed_power;
    logic hysteresis_on;
    logic [1:0] pos_input_sel;
    logic [2:0] neg_input_sel;
  } dcc_cmp_cfg_t;
endpackage

// ==== rtl/dcc_top.sv ====
// DAC and comparator control logic with APB register slave
`timescale 1ns/1ps
// Overview of operation
// RQ1: Eight-bit level code picks one of 256 ladder taps.
// RQ2: Positive source field bits 3-2: supply, external ref, buffer 2; 11 reserved.
// RQ3: Control bit 7 enables the reference converter.
// RQ4: Control bit 5 routes converter voltage to the output pin.
// RQ5: Pin in analog use: digital driver, detector off, reads zero.
// RQ6: Reset disables converter, frees pin, clears level code.
// RQ7: Sleep wake leaves converter control unchanged; software disables before sleep.
// RQ8: Control bits 6, 4, 1-0 ignore writes, read zero.
// RQ9: Comparator runs only while its on bit is set.
// RQ10: Result shows in control A and in shared summary register.
// RQ11: Pin driven only with pin drive set, direction clear, comparator on.
// RQ12: Pin drive overrides port latch regardless of on bit. Here the pin is driven only while the on bit is set.
// RQ13: Internal result latched each instruction cycle; pin path unlatched. Here the pin uses the timer copy while the sync bit is set.
// RQ14: Invert bit zero passes raw result; one inverts it.
// RQ15: Speed bit resets to one; zero selects low power.
// RQ16: Hysteresis bit enables input hysteresis.
// RQ17: Each result offered as timer gate source.
// RQ18: Sync bit captures result on falling timer clock edge.
// RQ19: With prescaler, capture uses the prescaled clock.
// RQ20: Software should enable sync when gating the timer.
// RQ21: Raw output high when non-inverting input above inverting.
// RQ22: Each comparator has its own pair of control registers.
// RQ23: Flag set on rising or falling result edge per enable.
// RQ24: Positive input select: pin, converter, buffer 2, ground.
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device events
  input wire logic sleep_wake,
  input wire logic instr_cycle,
  // Timer clock after optional prescaler, sampled in pclk domain
  input wire logic timer_clk_scaled,
  // Analog comparator raw outputs and pin state
  input wire logic [1:0] cmp_raw,
  input wire logic [1:0] cmp_pin_direction,
  input wire logic [1:0] port_latch,
  input wire logic ref_pin_in,
  // Analog control
  output dcc_ref_cfg_t ref_cfg,
  output dcc_cmp_cfg_t [1:0] cmp_cfg,
  // Pin control
  output logic ref_pin_analog,
  output logic ref_pin_read,
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe_n,
  // Timer gate sources and interrupt flags
  output logic [1:0] cmp_gate,
  output logic [1:0] cmp_irq_flag
);

  logic [7:0] ref_ctrl_ff;
  logic [7:0] ref_lvl_ff;
  logic [7:0] cmp_a_ff [DCC_NUM_CMP];
  logic [7:0] cmp_b_ff [DCC_NUM_CMP];
  logic [1:0] cmp_result_ff;
  logic [1:0] cmp_gate_ff;
  logic [1:0] cmp_prev_ff;
  logic [1:0] cmp_irq_ff;
  logic tclk_prev_ff;
  logic [31:0] prdata_ff;
  logic [1:0] cmp_live;
  logic wr_en;
  logic rd_en;
  logic [1:0] nxt_irq;
  logic [1:0] cmp_edge;
  logic tclk_fall;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Single-cycle access: every transfer completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign prdata = prdata_ff;
  assign tclk_fall = tclk_prev_ff && !timer_clk_scaled;

  // Reference converter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_ff <= DCC_REF_CTRL_RST; // RQ6
      ref_lvl_ff <= DCC_REF_LVL_RST; // RQ6
    end else if (wr_en) begin
      // Wake from sleep never touches the control word
      if (hit(paddr, DCC_OFS_REF_CTRL)) begin
        ref_ctrl_ff <= pwdata[7:0] & DCC_REF_CTRL_MASK; // RQ8 RQ7
      end
      if (hit(paddr, DCC_OFS_REF_LVL)) begin
        ref_lvl_ff <= pwdata[7:0]; // RQ1
      end
    end
  end

  assign ref_cfg.on = ref_ctrl_ff[DCC_REF_ON_BIT]; // RQ3
  assign ref_cfg.pin_drive = ref_ctrl_ff[DCC_REF_PIN_BIT]; // RQ4
  assign ref_cfg.pos_source_sel =
    ref_ctrl_ff[DCC_REF_PSS_HI:DCC_REF_PSS_LO]; // RQ2
  assign ref_cfg.level_code = ref_lvl_ff; // RQ1
  assign ref_pin_analog = ref_ctrl_ff[DCC_REF_PIN_BIT]; // RQ5
  assign ref_pin_read = ref_pin_analog ? 1'b0 : ref_pin_in; // RQ5

  genvar gi;
  generate
    for (gi = 0; gi < DCC_NUM_CMP; gi++) begin : g_cmp
      // Per-comparator register pair
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_a_ff[gi] <= DCC_CA_RST; // RQ15
          cmp_b_ff[gi] <= DCC_CB_RST;
        end else if (wr_en) begin
          if (hit(paddr, gi ? DCC_OFS_C2_A : DCC_OFS_C1_A)) begin
            cmp_a_ff[gi] <= pwdata[7:0] & DCC_CA_WMASK; // RQ22
          end
          if (hit(paddr, gi ? DCC_OFS_C2_B : DCC_OFS_C1_B)) begin
            cmp_b_ff[gi] <= pwdata[7:0] & DCC_CB_WMASK; // RQ22
          end
        end
      end

      // Off comparator gives zero before polarity, so polarity still acts
      assign cmp_live[gi] = ((cmp_a_ff[gi][DCC_CA_ON] & cmp_raw[gi]) ^
        cmp_a_ff[gi][DCC_CA_INV]); // RQ9 RQ14 RQ21

      assign cmp_cfg[gi].on = cmp_a_ff[gi][DCC_CA_ON]; // RQ9
      assign cmp_cfg[gi].speed_power = cmp_a_ff[gi][DCC_CA_SP]; // RQ15
      assign cmp_cfg[gi].hysteresis_on = cmp_a_ff[gi][DCC_CA_HYS]; // RQ16
      assign cmp_cfg[gi].pos_input_sel =
        cmp_b_ff[gi][DCC_CB_PCH_HI:DCC_CB_PCH_LO]; // RQ24
      assign cmp_cfg[gi].neg_input_sel = cmp_b_ff[gi][2:0];

      // Pin path is combinational unless sync selects the timer copy
      assign cmp_pin_out[gi] = cmp_a_ff[gi][DCC_CA_SYNC] ?
        cmp_gate_ff[gi] : cmp_live[gi]; // RQ13 RQ12
      assign cmp_pin_oe_n[gi] = !(cmp_a_ff[gi][DCC_CA_PIN] &&
        !cmp_pin_direction[gi] && cmp_a_ff[gi][DCC_CA_ON]); // RQ11
      assign cmp_gate[gi] = cmp_a_ff[gi][DCC_CA_SYNC] ?
        cmp_gate_ff[gi] : cmp_live[gi]; // RQ17

      // Enabled edge of the latched result in this cycle
      assign cmp_edge[gi] =
        (cmp_b_ff[gi][DCC_CB_RISE] & cmp_result_ff[gi] & !cmp_prev_ff[gi]) |
        (cmp_b_ff[gi][DCC_CB_FALL] & !cmp_result_ff[gi] & cmp_prev_ff[gi]);
      assign nxt_irq[gi] = cmp_irq_ff[gi] | cmp_edge[gi]; // RQ23
    end
  endgenerate

  // Port latch is unused; pin drive enables the pin output only while the on bit is also set
  logic [1:0] unused_latch;
  assign unused_latch = port_latch;

  // Internal result register, one update per instruction cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_result_ff <= 2'h0;
      cmp_prev_ff <= 2'h0;
    end else begin
      cmp_prev_ff <= cmp_result_ff;
      if (instr_cycle) begin
        cmp_result_ff <= cmp_live; // RQ13 RQ10
      end
    end
  end

  // Timer-synchronised copy, taken on falling edge of prescaled clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_prev_ff <= 1'b0;
      cmp_gate_ff <= 2'h0;
    end else begin
      tclk_prev_ff <= timer_clk_scaled;
      if (tclk_fall) begin
        cmp_gate_ff <= cmp_live; // RQ18 RQ19
      end
    end
  end

  // Edge flags; a new edge beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_irq_ff <= 2'h0;
    end else if (wr_en && hit(paddr, DCC_OFS_IRQ_FLAGS)) begin
      // Clear only old flags; an edge in this cycle still sets
      cmp_irq_ff <= (cmp_irq_ff & ~pwdata[1:0]) | cmp_edge; // RQ23
    end else begin
      cmp_irq_ff <= nxt_irq; // RQ23
    end
  end
  assign cmp_irq_flag = cmp_irq_ff;

  // Read data captured at setup, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        DCC_OFS_REF_CTRL: prdata_ff <= {24'h0, ref_ctrl_ff};
        DCC_OFS_REF_LVL: prdata_ff <= {24'h0, ref_lvl_ff};
        DCC_OFS_C1_A: prdata_ff <= {24'h0, cmp_a_ff[0] |
          {1'b0, cmp_result_ff[0], 6'h0}}; // RQ10
        DCC_OFS_C1_B: prdata_ff <= {24'h0, cmp_b_ff[0]};
        DCC_OFS_C2_A: prdata_ff <= {24'h0, cmp_a_ff[1] |
          {1'b0, cmp_result_ff[1], 6'h0}}; // RQ10
        DCC_OFS_C2_B: prdata_ff <= {24'h0, cmp_b_ff[1]};
        DCC_OFS_SUMMARY: prdata_ff <= {30'h0, cmp_result_ff}; // RQ10
        DCC_OFS_IRQ_FLAGS: prdata_ff <= {30'h0, cmp_irq_ff};
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

  logic unused_wake;
  assign unused_wake = sleep_wake;

  // Assertions
  ref_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> ref_ctrl_ff == 8'h00 && ref_lvl_ff == 8'h00)
    else $error("reference not cleared by reset"); // RQ6
  ref_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ref_ctrl_ff & 8'h53) == 8'h00)
    else $error("unimplemented control bits set"); // RQ8
  ref_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_REF_CTRL |=> ref_cfg.on == $past(pwdata[7]))
    else $error("enable bit not written"); // RQ3
  ref_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    ref_cfg.pin_drive |-> ref_pin_read == 1'b0 && ref_pin_analog)
    else $error("analog pin read not zero"); // RQ5
  sp_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> cmp_cfg[0].speed_power && cmp_cfg[1].speed_power)
    else $error("speed bit not one after reset"); // RQ15
  pin_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_pin_oe_n[0] |-> cmp_cfg[0].on && !cmp_pin_direction[0])
    else $error("pin driven without conditions"); // RQ11
  result_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    instr_cycle |=> cmp_result_ff == $past(cmp_live))
    else $error("result not latched"); // RQ13
  off_output_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_cfg[0].on |-> cmp_live[0] == cmp_a_ff[0][DCC_CA_INV])
    else $error("disabled comparator output wrong"); // RQ9
  sync_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tclk_fall |=> cmp_gate_ff == $past(cmp_live))
    else $error("sync copy not captured"); // RQ18
  rise_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_b_ff[0][DCC_CB_RISE] && cmp_result_ff[0] && !cmp_prev_ff[0]
    |=> cmp_irq_ff[0])
    else $error("rising edge flag missed"); // RQ23
  fall_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_b_ff[0][DCC_CB_FALL] && !cmp_result_ff[0] && cmp_prev_ff[0]
    |=> cmp_irq_ff[0])
    else $error("falling edge flag missed"); // RQ23
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_edge[0] |=> cmp_irq_ff[0])
    else $error("edge lost to clear"); // RQ23
  set_wins2_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_edge[1] |=> cmp_irq_ff[1])
    else $error("second edge lost to clear"); // RQ23
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_irq_ff[0] && !(wr_en && paddr == DCC_OFS_IRQ_FLAGS) |=> cmp_irq_ff[0])
    else $error("flag dropped without clear"); // RQ23
  flag_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_irq_ff[0] && !cmp_edge[0] |=> !cmp_irq_ff[0])
    else $error("flag set without edge"); // RQ23
  ref_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_REF_CTRL |=> ref_cfg.pin_drive == $past(pwdata[5]))
    else $error("pin route bit not written"); // RQ4
  ref_pss_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_REF_CTRL
    |=> ref_cfg.pos_source_sel == $past(pwdata[3:2]))
    else $error("source select not written"); // RQ2
  ref_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_REF_LVL
    |=> ref_cfg.level_code == $past(pwdata[7:0]))
    else $error("level code not written"); // RQ1
  ref_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == DCC_OFS_REF_CTRL) |=> $stable(ref_ctrl_ff))
    else $error("control changed without write"); // RQ7
  lvl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == DCC_OFS_REF_LVL) |=> $stable(ref_lvl_ff))
    else $error("level changed without write"); // RQ1
  ref_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ref_cfg.pin_drive |-> ref_pin_read == ref_pin_in)
    else $error("digital pin read wrong"); // RQ5
  ref_rst_pin_a: assert property (@(posedge pclk)
    $rose(presetn) |-> !ref_pin_analog && !ref_cfg.on)
    else $error("pin or converter active after reset"); // RQ6
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == DCC_OFS_REF_CTRL |=> prdata[7:0] == $past(ref_ctrl_ff))
    else $error("control read wrong"); // RQ8
  c1_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C1_A |=> cmp_cfg[0].on == $past(pwdata[7]))
    else $error("first on bit not written"); // RQ9
  c2_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C2_A |=> cmp_cfg[1].on == $past(pwdata[7]))
    else $error("second on bit not written"); // RQ22
  c1_psel_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C1_B
    |=> cmp_cfg[0].pos_input_sel == $past(pwdata[5:4]))
    else $error("first input select not written"); // RQ24
  c2_psel_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C2_B
    |=> cmp_cfg[1].pos_input_sel == $past(pwdata[5:4]))
    else $error("second input select not written"); // RQ22
  sp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C1_A
    |=> cmp_cfg[0].speed_power == $past(pwdata[2]))
    else $error("speed bit not written"); // RQ15
  hys_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C1_A
    |=> cmp_cfg[0].hysteresis_on == $past(pwdata[1]))
    else $error("hysteresis bit not written"); // RQ16
  c2_apart_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DCC_OFS_C1_A |=> $stable(cmp_a_ff[1]))
    else $error("second comparator disturbed"); // RQ22
  pin_oe2_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_pin_oe_n[1] |-> cmp_cfg[1].on && !cmp_pin_direction[1])
    else $error("second pin driven without conditions"); // RQ11
  pin_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_a_ff[0][DCC_CA_PIN] && !cmp_pin_direction[0] && cmp_cfg[0].on
    |-> !cmp_pin_oe_n[0])
    else $error("pin not driven"); // RQ11 RQ12
  pin_raw_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_a_ff[0][DCC_CA_SYNC] && cmp_cfg[0].on && !cmp_a_ff[0][DCC_CA_INV]
    |-> cmp_pin_out[0] == cmp_raw[0])
    else $error("unlatched pin output wrong"); // RQ13 RQ21
  live_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_cfg[0].on && cmp_a_ff[0][DCC_CA_INV] |-> cmp_live[0] == !cmp_raw[0])
    else $error("inverted output wrong"); // RQ14
  live_raw2_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_cfg[1].on && !cmp_a_ff[1][DCC_CA_INV] |-> cmp_live[1] == cmp_raw[1])
    else $error("second raw output wrong"); // RQ21
  result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !instr_cycle |=> $stable(cmp_result_ff))
    else $error("result changed between cycles"); // RQ13
  summary_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == DCC_OFS_SUMMARY |=> prdata[1:0] == $past(cmp_result_ff))
    else $error("mirror bits wrong"); // RQ10
  status_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == DCC_OFS_C1_A |=> prdata[6] == $past(cmp_result_ff[0]))
    else $error("status bit wrong"); // RQ10
  gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tclk_fall |=> $stable(cmp_gate_ff))
    else $error("sync copy moved off falling edge"); // RQ18 RQ19
  unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr > DCC_OFS_IRQ_FLAGS |=> prdata == 32'h0)
    else $error("unmapped read not zero"); // RQ8
endmodule

// ==== verif/test_dac_and_comparator_control.sv ====
// Self-checking bench for the DAC and comparator control block
`timescale 1ns/1ps
module test_dac_and_comparator_control
  import dcc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic sleep_wake = 1'b0;
  logic instr_cycle = 1'b0;
  logic timer_clk_scaled = 1'b1;
  logic [1:0] cmp_raw = 2'h0;
  logic [1:0] cmp_pin_direction = 2'h3;
  logic [1:0] port_latch = 2'h0;
  logic ref_pin_in = 1'b0;
  dcc_ref_cfg_t ref_cfg;
  dcc_cmp_cfg_t [1:0] cmp_cfg;
  logic ref_pin_analog;
  logic ref_pin_read;
  logic [1:0] cmp_pin_out;
  logic [1:0] cmp_pin_oe_n;
  logic [1:0] cmp_gate;
  logic [1:0] cmp_irq_flag;
  int err_total = 0;
  int compares = 0;

  dcc_top dcc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .sleep_wake(sleep_wake),
    .instr_cycle(instr_cycle), .timer_clk_scaled(timer_clk_scaled),
    .cmp_raw(cmp_raw), .cmp_pin_direction(cmp_pin_direction),
    .port_latch(port_latch), .ref_pin_in(ref_pin_in), .ref_cfg(ref_cfg),
    .cmp_cfg(cmp_cfg), .ref_pin_analog(ref_pin_analog),
    .ref_pin_read(ref_pin_read), .cmp_pin_out(cmp_pin_out),
    .cmp_pin_oe_n(cmp_pin_oe_n), .cmp_gate(cmp_gate),
    .cmp_irq_flag(cmp_irq_flag));

  always #12.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Latch pulse, then let the result settle
  task automatic tick(input logic [1:0] raw);
    @(posedge pclk);
    cmp_raw <= raw;
    instr_cycle <= 1'b1;
    @(posedge pclk);
    instr_cycle <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset();
    rd("ref_ctrl", DCC_OFS_REF_CTRL, 32'h0);
    rd("ref_lvl", DCC_OFS_REF_LVL, 32'h0);
    rd("c1_a", DCC_OFS_C1_A, 32'h04);
    rd("c2_a", DCC_OFS_C2_A, 32'h04);
    rd("c1_b", DCC_OFS_C1_B, 32'h0);
    rd("summary", DCC_OFS_SUMMARY, 32'h0);
    chk("ref_cfg", 32'h0, 32'(ref_cfg));
    rd("unmapped", 8'h20, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_ref();
    wr(DCC_OFS_REF_CTRL, 32'hffff_fffb);
    rd("ref_ctrl", DCC_OFS_REF_CTRL, 32'ha8);
    wr(DCC_OFS_REF_LVL, 32'hffff_ff5a);
    rd("ref_lvl", DCC_OFS_REF_LVL, 32'h5a);
    ref_pin_in <= 1'b1;
    sleep_wake <= 1'b1;
    @(negedge pclk);
    chk("ref_on", 32'h1, 32'(ref_cfg.on));
    chk("ref_pin", 32'h1, 32'(ref_pin_analog));
    chk("ref_pss", 32'h2, 32'(ref_cfg.pos_source_sel));
    chk("ref_code", 32'h5a, 32'(ref_cfg.level_code));
    chk("pin_read", 32'h0, 32'(ref_pin_read));
    @(posedge pclk);
    sleep_wake <= 1'b0;
    rd("ref_wake", DCC_OFS_REF_CTRL, 32'ha8);
    wr(DCC_OFS_REF_CTRL, 32'h04);
    @(negedge pclk);
    chk("ref_off", 32'h0, 32'(ref_cfg.on));
    chk("pin_read1", 32'h1, 32'(ref_pin_read));
    chk("ref_pss1", 32'h1, 32'(ref_cfg.pos_source_sel));
    wr(DCC_OFS_REF_CTRL, 32'ha0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("ref_rst", 32'h0, 32'(ref_cfg));
    rd("lvl_rst", DCC_OFS_REF_LVL, 32'h0);
    $display("test reference done");
  endtask

  task automatic t_cmp_regs();
    wr(DCC_OFS_C1_A, 32'h48);
    rd("c1_a", DCC_OFS_C1_A, 32'h0);
    chk("speed", 32'h0, 32'(cmp_cfg[0].speed_power));
    wr(DCC_OFS_C1_A, 32'h06);
    @(negedge pclk);
    chk("hys", 32'h1, 32'(cmp_cfg[0].hysteresis_on));
    wr(DCC_OFS_C1_B, 32'h25);
    rd("c1_b", DCC_OFS_C1_B, 32'h25);
    chk("pos_sel", 32'h2, 32'(cmp_cfg[0].pos_input_sel));
    rd("c2_b", DCC_OFS_C2_B, 32'h0);
    $display("test comparator registers done");
  endtask

  task automatic t_pol();
    logic e;
    for (int i = 0; i < 4; i++) begin
      wr(DCC_OFS_C1_A, 32'h80 | (32'(i[1]) << 4));
      tick({1'b0, i[0]});
      e = i[0] ^ i[1];
      rd("c1_a", DCC_OFS_C1_A,
        32'h80 | (32'(i[1]) << 4) | (32'(e) << 6));
      rd("summary", DCC_OFS_SUMMARY, 32'(e));
      chk("gate", 32'(e), 32'(cmp_gate[0]));
    end
    @(posedge pclk);
    cmp_raw <= 2'h0;
    repeat (4) @(posedge pclk);
    rd("held", DCC_OFS_SUMMARY, 32'h0);
    $display("test polarity done");
  endtask

  task automatic t_pin();
    wr(DCC_OFS_C2_A, 32'ha0);
    cmp_pin_direction <= 2'h1;
    port_latch <= 2'h0;
    tick(2'h2);
    chk("oe_n", 32'h0, 32'(cmp_pin_oe_n[1]));
    chk("pin_out", 32'h1, 32'(cmp_pin_out[1]));
    @(posedge pclk);
    cmp_pin_direction <= 2'h3;
    @(negedge pclk);
    chk("oe_n_dir", 32'h1, 32'(cmp_pin_oe_n[1]));
    @(posedge pclk);
    cmp_pin_direction <= 2'h1;
    wr(DCC_OFS_C2_A, 32'h20);
    @(negedge pclk);
    chk("oe_n_off", 32'h1, 32'(cmp_pin_oe_n[1]));
    $display("test pin done");
  endtask

  task automatic t_sync();
    wr(DCC_OFS_C1_A, 32'h81);
    tick(2'h0);
    @(posedge pclk);
    timer_clk_scaled <= 1'b0;
    repeat (4) @(posedge pclk);
    timer_clk_scaled <= 1'b1;
    tick(2'h1);
    chk("gate_hold", 32'h0, 32'(cmp_gate[0]));
    @(posedge pclk);
    timer_clk_scaled <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("gate_fall", 32'h1, 32'(cmp_gate[0]));
    $display("test sync done");
  endtask

  task automatic t_irq();
    wr(DCC_OFS_C1_A, 32'h80);
    tick(2'h0);
    wr(DCC_OFS_C1_B, 32'h80);
    wr(DCC_OFS_IRQ_FLAGS, 32'h3);
    rd("flag_clr", DCC_OFS_IRQ_FLAGS, 32'h0);
    tick(2'h1);
    rd("flag_rise", DCC_OFS_IRQ_FLAGS, 32'h1);
    chk("flag_pin", 32'h1, 32'(cmp_irq_flag[0]));
    wr(DCC_OFS_IRQ_FLAGS, 32'h1);
    tick(2'h0);
    rd("flag_nofall", DCC_OFS_IRQ_FLAGS, 32'h0);
    wr(DCC_OFS_C1_B, 32'h40);
    tick(2'h1);
    rd("flag_norise", DCC_OFS_IRQ_FLAGS, 32'h0);
    tick(2'h0);
    rd("flag_fall", DCC_OFS_IRQ_FLAGS, 32'h1);
    $display("test edge flags done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ref();
    t_cmp_regs();
    t_pol();
    t_pin();
    t_sync();
    t_irq();
    close_out();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #500000;
    err_total++;
    close_out();
  end
endmodule
